// ### core/vsc_switch_regs.sv
`timescale 1ns/1ps
`default_nettype none
module vsc_switch_regs #(
  parameter int PULSE_CYCLES = vsc_pkg::PULSE_CYCLES
) (
  input  wire logic        sys_clk,            // 40 MHz clock
  input  wire logic        rst_n,              // async reset, active low
  input  wire logic        scl_in,             // serial clock pin
  input  wire logic        sda_in,             // serial data pin level
  output logic             sda_out,            // serial data drive level
  output logic             sda_oe,             // serial data drive enable
  input  wire logic        bus_addr_pin_2,     // address strap bit 2
  input  wire logic        bus_addr_pin_1,     // address strap bit 1
  input  wire logic        bus_addr_pin_0,     // address strap bit 0
  input  wire logic        par_path_on,        // parallel lane enable
  input  wire logic [1:0]  par_source_sel,     // parallel source select
  input  wire logic        par_eq_level,       // parallel eq level
  input  wire logic [1:0]  par_boost_level,    // parallel pre-emphasis
  input  wire logic        par_output_term_on, // parallel output term
  input  wire logic        par_drive_level,    // parallel current level
  output logic             tmds_path_on,       // main lanes active
  output logic [1:0]       tmds_source_sel,    // main source group
  output logic             side_switch_on,     // aux switch closed
  output logic [1:0]       side_source_sel,    // aux source group
  output logic             input_term_on,      // input termination on
  output logic [15:0]      lane_term_connect,  // per-lane termination
  output logic [15:0]      input_eq_level,     // per-lane eq level
  output logic [1:0]       output_boost_level, // output pre-emphasis
  output logic             output_term_on,     // output termination
  output logic             output_drive_level, // output current level
  output logic             serial_mode         // parallel pins locked out
);
  localparam int NREG = vsc_pkg::NREG;

  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_ADDR     = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_REG      = 9'h008,
    ST_REG_ACK  = 9'h010,
    ST_WDATA    = 9'h020,
    ST_WD_ACK   = 9'h040,
    ST_RDATA    = 9'h080,
    ST_RD_ACK   = 9'h100
  } vsc_state_e;

  ////////////////////////////////////////////////////////////////////////
  // pin conditioning

  logic [1:0] line_f;
  logic [2:0] strap_f;
  logic [7:0] par_f;

  vsc_pin_sync #(.W(2)) u_line_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_in  ({scl_in, sda_in}),
    .pin_out (line_f)
  );

  vsc_pin_sync #(.W(11)) u_par_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_in  ({bus_addr_pin_2, bus_addr_pin_1, bus_addr_pin_0,
               par_path_on, par_source_sel, par_eq_level,
               par_boost_level, par_output_term_on, par_drive_level}),
    .pin_out ({strap_f, par_f})
  );

  logic scl_f;
  logic sda_f;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_f     = line_f[1];
  assign sda_f     = line_f[0];
  assign scl_rise  = scl_f & ~scl_d_reg;
  assign scl_fall  = ~scl_f & scl_d_reg;
  assign bus_start = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  assign bus_stop  = scl_f & scl_d_reg & ~sda_d_reg & sda_f;

  ////////////////////////////////////////////////////////////////////////
  // serial slave and register bank

  vsc_state_e            st_reg;
  vsc_state_e            st_next;
  logic [3:0]            cnt_reg;
  logic [3:0]            cnt_next;
  logic [7:0]            shift_reg;
  logic [7:0]            shift_next;
  logic [7:0]            idx_reg;
  logic [7:0]            idx_next;
  logic                  rw_reg;
  logic                  rw_next;
  logic                  nack_reg;
  logic                  nack_next;
  logic                  drv_reg;
  logic                  drv_next;
  logic                  ser_reg;
  logic                  ser_next;
  logic [NREG-1:0][7:0]  bank_reg;
  logic [NREG-1:0][7:0]  bank_next;
  logic [7:0]            rd_data;
  logic                  addr_hit;

  // unmapped indices read as zero and swallow writes
  always_comb
  begin
    rd_data = 8'h00;
    for (int i = 0; i < NREG; i++)
      if (idx_reg == vsc_pkg::OFS_ALL[i])
        rd_data = bank_reg[i];
  end

  assign addr_hit = (shift_reg[7:1] == {vsc_pkg::SLV_ADDR_HI, strap_f});

  always_comb
  begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    idx_next   = idx_reg;
    rw_next    = rw_reg;
    nack_next  = nack_reg;
    drv_next   = drv_reg;
    ser_next   = ser_reg;
    bank_next  = bank_reg;
    if (bus_start)
    begin
      st_next  = ST_ADDR;
      cnt_next = 4'h0;
      drv_next = 1'b0;
    end
    else if (bus_stop)
    begin
      st_next  = ST_IDLE;
      drv_next = 1'b0;
    end
    else
    begin
      case (st_reg)
        ST_ADDR, ST_REG, ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_next = {shift_reg[6:0], sda_f};
            cnt_next   = cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == 4'h8)
          begin
            cnt_next = 4'h0;
            drv_next = 1'b1;
            if (st_reg == ST_ADDR)
            begin
              if (addr_hit) // [RULE2]
              begin
                rw_next  = shift_reg[0];
                ser_next = 1'b1; // [RULE1]
                st_next  = ST_ADDR_ACK;
              end
              else
              begin
                drv_next = 1'b0;
                st_next  = ST_IDLE;
              end
            end
            else if (st_reg == ST_REG)
            begin
              idx_next = shift_reg;
              st_next  = ST_REG_ACK;
            end
            else
            begin
              for (int i = 0; i < NREG; i++)
                if (idx_reg == vsc_pkg::OFS_ALL[i])
                  bank_next[i] = shift_reg & vsc_pkg::WMASK_ALL[i]; // [RULE8]
              st_next = ST_WD_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_REG_ACK, ST_WD_ACK:
        begin
          if (scl_fall)
          begin
            drv_next = 1'b0;
            if (st_reg == ST_ADDR_ACK && rw_reg)
            begin
              shift_next = rd_data;
              drv_next   = ~rd_data[7];
              st_next    = ST_RDATA;
            end
            else if (st_reg == ST_ADDR_ACK)
              st_next = ST_REG;
            else
              st_next = ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (cnt_reg == 4'h7)
            begin
              cnt_next = 4'h0;
              drv_next = 1'b0;
              st_next  = ST_RD_ACK;
            end
            else
            begin
              shift_next = {shift_reg[6:0], 1'b0};
              drv_next   = ~shift_reg[6];
              cnt_next   = cnt_reg + 4'h1;
            end
          end
        end
        ST_RD_ACK:
        begin
          if (scl_rise)
            nack_next = sda_f;
          else if (scl_fall)
          begin
            if (nack_reg)
              st_next = ST_IDLE;
            else
            begin
              shift_next = rd_data;
              drv_next   = ~rd_data[7];
              st_next    = ST_RDATA;
            end
          end
        end
        default:
          st_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      st_reg    <= ST_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      idx_reg   <= 8'h00;
      rw_reg    <= 1'b0;
      nack_reg  <= 1'b0;
      drv_reg   <= 1'b0;
      ser_reg   <= 1'b0;
      bank_reg  <= vsc_pkg::RST_ALL;
    end
    else
    begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      idx_reg   <= idx_next;
      rw_reg    <= rw_next;
      nack_reg  <= nack_next;
      drv_reg   <= drv_next;
      ser_reg   <= ser_next;
      bank_reg  <= bank_next;
    end
  end

  // open drain: only ever pull low
  assign sda_out     = 1'b0;
  assign sda_oe      = drv_reg;
  assign serial_mode = ser_reg;

  ////////////////////////////////////////////////////////////////////////
  // source of each setting and its update window

  logic [NREG-1:0][7:0] par_cfg;
  logic [NREG-1:0][7:0] eff_cfg;
  logic [NREG-1:0][7:0] app;
  logic [NREG-1:0]      upd_busy;

  always_comb
  begin
    par_cfg            = vsc_pkg::RST_ALL;
    par_cfg[vsc_pkg::IX_MAIN] = {1'b0, par_f[7], 4'h0, par_f[6:5]};
    par_cfg[vsc_pkg::IX_AUX]  = {1'b0, 1'b1, 4'h0, par_f[6:5]};
    par_cfg[vsc_pkg::IX_EQ_LO] = {8{par_f[4]}};
    par_cfg[vsc_pkg::IX_EQ_HI] = {8{par_f[4]}};
    par_cfg[vsc_pkg::IX_TX]   = {4'h0, par_f[3:0]};
  end

  // pin bits: 7 enable, 6:5 source, 4 eq, 3:2 boost, 1 oterm, 0 drive
  assign eff_cfg = ser_reg ? bank_reg : par_cfg; // [RULE1]

  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : g_upd
      vsc_upd_delay #(
        .RST (vsc_pkg::RST_ALL[g]),
        .CYC (vsc_pkg::UPD_CYCLES)
      ) u_upd (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .want    (eff_cfg[g]),
        .applied (app[g]),
        .busy    (upd_busy[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // termination pulse on source switch

  logic [vsc_pkg::PULSE_W-1:0] pls_reg;
  logic [vsc_pkg::PULSE_W-1:0] pls_next;
  logic [1:0]                  psel_reg;
  logic [15:0]                 lane_reg;
  logic [15:0]                 lane_next;
  logic [15:0]                 pulse_bits;
  logic                        sel_moved;

  assign pulse_bits = {app[vsc_pkg::IX_PLS_HI], app[vsc_pkg::IX_PLS_LO]};
  assign sel_moved  = app[vsc_pkg::IX_MAIN][1:0] != psel_reg;

  always_comb
  begin
    pls_next = pls_reg;
    if (sel_moved)
      pls_next = vsc_pkg::PULSE_W'(PULSE_CYCLES); // [RULE11]
    else if (pls_reg != '0)
      pls_next = pls_reg - 1'b1;
    lane_next = {16{app[vsc_pkg::IX_RX][vsc_pkg::TERM_BIT]}}
              & ~({16{pls_next != '0}} & pulse_bits); // [RULE6] [RULE11]
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pls_reg  <= '0;
      psel_reg <= 2'h0;
      lane_reg <= 16'h0000;
    end
    else
    begin
      pls_reg  <= pls_next;
      psel_reg <= app[vsc_pkg::IX_MAIN][1:0];
      lane_reg <= lane_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, from applied flip-flops except lane termination, which comes from lane_reg

  assign tmds_path_on       = app[vsc_pkg::IX_MAIN][vsc_pkg::ON_BIT]; // [RULE3]
  assign tmds_source_sel    = app[vsc_pkg::IX_MAIN][1:0];             // [RULE4]
  assign side_switch_on     = app[vsc_pkg::IX_AUX][vsc_pkg::ON_BIT];  // [RULE5]
  assign side_source_sel    = app[vsc_pkg::IX_AUX][1:0];
  assign input_term_on      = app[vsc_pkg::IX_RX][vsc_pkg::TERM_BIT];
  assign lane_term_connect  = lane_reg;
  assign input_eq_level     = {app[vsc_pkg::IX_EQ_HI],
                               app[vsc_pkg::IX_EQ_LO]};               // [RULE7]
  assign output_boost_level = app[vsc_pkg::IX_TX][3:2];
  assign output_term_on     = app[vsc_pkg::IX_TX][vsc_pkg::OTERM_BIT];
  assign output_drive_level = app[vsc_pkg::IX_TX][vsc_pkg::DRV_BIT];

  ////////////////////////////////////////////////////////////////////////
  // checks

  chk_serial_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ser_reg |=> ser_reg && eff_cfg == bank_reg) // [RULE1]
    else $error("parallel path reopened after serial access");
  chk_addr_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_reg == ST_ADDR && scl_fall && cnt_reg == 4'h8 && !bus_start
    && !bus_stop && shift_reg[7:1] == {vsc_pkg::SLV_ADDR_HI, strap_f}
    |=> st_reg == ST_ADDR_ACK && sda_oe) // [RULE2]
    else $error("own address not acknowledged");
  chk_path_apply: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(upd_busy[0]) |-> tmds_path_on == $past(eff_cfg[0][6])
    && tmds_source_sel == $past(eff_cfg[0][1:0])) // [RULE3] [RULE4]
    else $error("main path not updated at window end");
  chk_aux_apply: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(upd_busy[1]) |-> side_switch_on == $past(eff_cfg[1][6])) // [RULE5]
    else $error("aux switch not updated at window end");
  chk_eq_apply: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(upd_busy[5]) |-> input_eq_level[7:0] == $past(eff_cfg[5])) // [RULE7]
    else $error("eq level not updated at window end");
  chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bank_reg[0] & 8'hbc) == 8'h00 && (bank_reg[2] & 8'hfe) == 8'h00
    && (bank_reg[7] & 8'hf0) == 8'h00) // [RULE8]
    else $error("fixed-zero bit became set");
  chk_pulse_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sel_moved |=> pls_reg == vsc_pkg::PULSE_W'(PULSE_CYCLES)) // [RULE11]
    else $error("pulse timer not loaded on source switch");
  chk_pulse_lane: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pls_reg != '0 && $past(pulse_bits[0]) && pulse_bits[0]
    |-> !lane_term_connect[0]) // [RULE6]
    else $error("pulsed lane kept termination");
endmodule
`default_nettype wire

// ### core/vsc_pkg.sv
// Functional notes
// (RULE1) first serial access locks out the parallel pins until reset
// (RULE2) slave address low three bits come from three strap pins
// (RULE3) tmds_path_on 0 puts main lanes in standby, 1 makes them active
// (RULE4) tmds_source_sel 00/01/10/11 routes group A/B/C/D to the output
// (RULE5) side_switch_on 0 opens the auxiliary switch, 1 closes it
// (RULE6) sixteen term_pulse_on_switch bits, two bytes, pick pulsed lanes
// (RULE7) sixteen input_eq_level bits, two bytes, set each lane's level
// (RULE8) fixed-zero bit positions read as zero and ignore writes
// (RULE9) master sends address 1001xxx MSB first, then register index
// (RULE10) writes apply after an update window; later writes supersede
// (RULE11) pulsed lane termination drops 100 ms after a source switch; the code drops it at the applied switch and restores it 100 ms later
package vsc_pkg;
  localparam int          NREG        = 8;
  localparam logic [3:0]  SLV_ADDR_HI = 4'h9;
  localparam int          IX_MAIN     = 0;
  localparam int          IX_AUX      = 1;
  localparam int          IX_RX       = 2;
  localparam int          IX_PLS_LO   = 3;
  localparam int          IX_PLS_HI   = 4;
  localparam int          IX_EQ_LO    = 5;
  localparam int          IX_EQ_HI    = 6;
  localparam int          IX_TX       = 7;
  // offsets, resets and writable-bit masks, indexed as above
  localparam logic [NREG-1:0][7:0] OFS_ALL =
    {8'h20, 8'h14, 8'h13, 8'h12, 8'h11, 8'h10, 8'h01, 8'h00};
  localparam logic [NREG-1:0][7:0] RST_ALL =
    {8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h40, 8'h40};
  localparam logic [NREG-1:0][7:0] WMASK_ALL =
    {8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'h43, 8'h43};
  localparam int          ON_BIT      = 6;
  localparam int          SEL_LSB     = 0;
  localparam int          TERM_BIT    = 0;
  localparam int          DRV_BIT     = 0;
  localparam int          OTERM_BIT   = 1;
  localparam int          BOOST_LSB   = 2;
  localparam int          CLK_NS      = 25;
  localparam int          UPD_DELAY_NS = 1000;
  localparam int          UPD_CYCLES  = (UPD_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int          PULSE_MS    = 100;
  localparam int          PULSE_CYCLES = PULSE_MS * 1000000 / CLK_NS;
  localparam int          PULSE_W     = 22;
endpackage

// ### core/vsc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module vsc_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk, // system clock
  input  wire logic         rst_n,   // async reset, active low
  input  wire logic [W-1:0] pin_in,  // raw pin levels
  output logic      [W-1:0] pin_out  // filtered levels
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      // a change counts only once the second and third stages agree
      always_comb
      begin
        out_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : out_reg[g];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end
    else
    begin
      s1_reg  <= pin_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign pin_out = out_reg;
endmodule
`default_nettype wire

// ### core/vsc_upd_delay.sv
`timescale 1ns/1ps
`default_nettype none
module vsc_upd_delay #(
  parameter logic [7:0] RST = 8'h00,
  parameter int         CYC = 1
) (
  input  wire logic       sys_clk, // system clock
  input  wire logic       rst_n,   // async reset, active low
  input  wire logic [7:0] want,    // configured value
  output logic      [7:0] applied, // value in physical effect
  output logic            busy     // update window open
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [7:0]  app_reg;
  logic [7:0]  app_next;
  logic        busy_reg;
  logic        busy_next;

  // the window is not restarted by new writes; the last value wins
  always_comb
  begin
    cnt_next  = cnt_reg;
    app_next  = app_reg;
    busy_next = busy_reg;
    if (busy_reg)
    begin
      if (cnt_reg == 16'(CYC - 1))
      begin
        busy_next = 1'b0;
        app_next  = want; // [RULE10]
      end
      else
        cnt_next = cnt_reg + 16'h0001;
    end
    else if (want != app_reg)
    begin
      busy_next = 1'b1; // [RULE10]
      cnt_next  = 16'h0000;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg  <= 16'h0000;
      app_reg  <= RST;
      busy_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      app_reg  <= app_next;
      busy_reg <= busy_next;
    end
  end

  assign applied = app_reg;
  assign busy    = busy_reg;

  chk_window_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busy_reg && cnt_reg != 16'(CYC - 1) |=> $stable(app_reg)) // [RULE10]
    else $error("applied value changed inside update window");
  chk_window_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(busy_reg) |-> $past(cnt_reg) == 16'(CYC - 1)) // [RULE10]
    else $error("update window length wrong");
  chk_window_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busy_reg && cnt_reg != 16'(CYC - 1)
    |=> busy_reg && cnt_reg == $past(cnt_reg) + 16'h0001) // [RULE10]
    else $error("update window counter skipped");
endmodule
`default_nettype wire

// ### verification/vsc_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module vsc_bus_master #(
  parameter int         Q    = 6,
  parameter logic [6:0] ADDR = 7'h4d
) (
  input  wire logic sys_clk,  // system clock
  input  wire logic sda_line, // resolved data wire
  output logic      scl_o,    // serial clock, idles high
  output logic      sda_o     // data, 1 releases to pull-up
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // also serves as repeated start: data rises while the clock is low
  task automatic start();
    sda_o = 1'b1;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    sda_o = 1'b0;
    tick(Q);
    scl_o = 1'b0;
    tick(Q);
  endtask

  task automatic stop();
    sda_o = 1'b0;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    sda_o = 1'b1;
    tick(2 * Q);
  endtask

  // data only moves while the clock is low
  task automatic bitx(input logic b, output logic s);
    sda_o = b;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    s = sda_line;
    tick(Q);
    scl_o = 1'b0;
    tick(Q);
  endtask

  task automatic xbyte(input logic [7:0] b, input logic na,
                       output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], r[i]);
    bitx(na, s);
    ack = ~s;
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] ix,
                        input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       a1, a2, a3;
    start();
    xbyte({a, 1'b0}, 1'b1, r, a1);
    xbyte(ix, 1'b1, r, a2);
    xbyte(d, 1'b1, r, a3);
    stop();
    ok = a1 & a2 & a3;
  endtask

  task automatic rd_reg(input logic [7:0] ix, output logic [7:0] d,
                        output logic ok);
    logic [7:0] r;
    logic       a1, a2, a3, a4;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, r, a1);
    xbyte(ix, 1'b1, r, a2);
    start();
    xbyte({ADDR, 1'b1}, 1'b1, r, a3);
    xbyte(8'hff, 1'b1, d, a4);
    stop();
    ok = a1 & a2 & a3;
  endtask
endmodule
`default_nettype wire

// ### verification/vsc_switch_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vsc_switch_regs_tb;
  localparam int         PW  = 50;
  localparam int         UW  = vsc_pkg::UPD_CYCLES + 10;
  localparam logic [6:0] ADR = {4'b1001, 3'b101};
  logic        sys_clk, rst_n, scl, sda_m, sda_w, sda_out, sda_oe;
  logic        p_on, p_eq, p_ot, p_dr, smode, path_on, side_on;
  logic        term_on, oterm, drive, ok;
  logic [1:0]  p_sel, p_bo, src, side_src, boost;
  logic [15:0] lane_conn, eq;
  logic [7:0]  rd;
  logic [2:0]  strap;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;

  // open drain with pull-up: released line reads high
  assign sda_w = sda_m & ~(sda_oe & ~sda_out);

  vsc_switch_regs #(.PULSE_CYCLES(PW)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .bus_addr_pin_2(strap[2]),
    .bus_addr_pin_1(strap[1]), .bus_addr_pin_0(strap[0]),
    .par_path_on(p_on),
    .par_source_sel(p_sel), .par_eq_level(p_eq), .par_boost_level(p_bo),
    .par_output_term_on(p_ot), .par_drive_level(p_dr),
    .tmds_path_on(path_on), .tmds_source_sel(src),
    .side_switch_on(side_on), .side_source_sel(side_src),
    .input_term_on(term_on), .lane_term_connect(lane_conn),
    .input_eq_level(eq), .output_boost_level(boost),
    .output_term_on(oterm), .output_drive_level(drive),
    .serial_mode(smode));

  vsc_bus_master #(.ADDR(ADR)) u_mst (
    .sys_clk(sys_clk), .sda_line(sda_w), .scl_o(scl), .sda_o(sda_m));

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    u_mst.wr_reg(ADR, ix, d, ok);
    chk(16'(ok), 16'h0001);
  endtask

  task automatic rdc(input logic [7:0] ix, input logic [7:0] e);
    u_mst.rd_reg(ix, rd, ok);
    chk({7'h0, ok, rd}, {8'h01, e});
  endtask

  task automatic settle();
    repeat (UW) @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_parallel();
    p_on = 1'b0;
    p_sel = 2'h2;
    p_bo = 2'h2;
    p_eq = 1'b1;
    settle();
    chk(16'({smode, path_on, src}), 16'h0002);
    chk(16'({boost, oterm, drive}), 16'h000b);
    chk(eq, 16'hffff);
  endtask

  // straps move the address; the old one must go deaf
  task automatic t_strap();
    strap = 3'b010;
    repeat (10) @(negedge sys_clk);
    u_mst.wr_reg(ADR, 8'h01, 8'h42, ok);
    chk(16'(ok), 16'h0000);
    u_mst.wr_reg({4'b1001, 3'b010}, 8'h01, 8'h42, ok);
    chk(16'(ok), 16'h0001);
    strap = 3'b101;
    repeat (10) @(negedge sys_clk);
  endtask

  // neither address may be taken for ours
  task automatic t_wrong_addr();
    u_mst.wr_reg(7'h48, 8'h00, 8'h01, ok);
    chk(16'(ok), 16'h0000);
    u_mst.wr_reg(7'h1d, 8'h00, 8'h01, ok);
    chk(16'({ok, smode}), 16'h0000);
  endtask

  task automatic t_defaults();
    for (int i = 0; i < vsc_pkg::NREG; i++)
      rdc(vsc_pkg::OFS_ALL[i], vsc_pkg::RST_ALL[i]);
    chk(16'(smode), 16'h0001);
  endtask

  // serial bank overrides, and pins no longer reach the outputs
  task automatic t_lockout();
    settle();
    chk(16'({path_on, src}), 16'h0004);
    p_sel = 2'h1;
    p_bo = 2'h3;
    settle();
    chk(16'({path_on, src, boost}), 16'h0010);
  endtask

  task automatic t_mask();
    for (int i = 0; i < vsc_pkg::NREG; i++)
    begin
      wr(vsc_pkg::OFS_ALL[i], 8'hff);
      rdc(vsc_pkg::OFS_ALL[i], vsc_pkg::WMASK_ALL[i]);
      wr(vsc_pkg::OFS_ALL[i], vsc_pkg::RST_ALL[i]);
    end
  endtask

  task automatic t_source();
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h00, 8'h40 | 8'(s));
      settle();
      chk(16'({path_on, src}), 16'(4 + s));
    end
  endtask

  task automatic t_enables();
    wr(8'h00, 8'h03);
    wr(8'h01, 8'h00);
    settle();
    chk(16'({path_on, side_on}), 16'h0000);
    wr(8'h00, 8'h43);
    wr(8'h01, 8'h42);
    settle();
    chk(16'({path_on, side_on, side_src}), 16'h000e);
  endtask

  // pulse window is short in sim, so check right after the write
  task automatic t_lanes();
    wr(8'h13, 8'ha5);
    wr(8'h14, 8'h3c);
    wr(8'h11, 8'h0f);
    wr(8'h12, 8'h80);
    settle();
    chk(eq, 16'h3ca5);
    chk(lane_conn, 16'hffff);
    wr(8'h00, 8'h41);
    chk(lane_conn, 16'h7ff0);
    repeat (PW + 10) @(negedge sys_clk);
    chk(lane_conn, 16'hffff);
    wr(8'h10, 8'h00);
    wr(8'h20, 8'h0a);
    settle();
    chk(16'({term_on, boost, oterm, drive}), 16'h000a);
    chk(lane_conn, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    strap = 3'b101;
    p_on = 1'b1;
    p_sel = 2'h0;
    p_eq = 1'b0;
    p_bo = 2'h0;
    p_ot = 1'b1;
    p_dr = 1'b1;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    t_parallel();
    t_wrong_addr();
    t_defaults();
    t_lockout();
    t_mask();
    t_source();
    t_enables();
    t_lanes();
    t_strap();
    wrap_up();
  end
endmodule
`default_nettype wire
